//--- src/tmr8_pkg.sv
// constants, field layouts and carrier types for the 8-bit timer with output compare
package tmr8_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
	localparam logic [ADDR_W-1:0] COUNT_OFS   = 8'h04;
	localparam logic [ADDR_W-1:0] COMPARE_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] FLAGS_OFS   = 8'h0C;
	localparam logic [ADDR_W-1:0] IRQEN_OFS   = 8'h10;

	// bit positions in the flag and irq enable registers
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;

	// waveform_mode encodings
	localparam logic [1:0] WAVE_NORMAL         = 2'h0;
	localparam logic [1:0] WAVE_PHASE_PWM      = 2'h1;
	localparam logic [1:0] WAVE_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] WAVE_FAST_PWM       = 2'h3;

	// compare_output_mode encodings (non-PWM meaning)
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	localparam logic [CNT_W-1:0] COUNT_BOTTOM = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_MAX    = 8'hFF;

	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [1:0] IRQEN_RESET   = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// prescaler masks per clock_select; index 0 means stopped
	localparam int PRESC_W = 10;
	localparam logic [PRESC_W-1:0] PRESCALE_MASK [8] = '{
		10'h000, 10'h000, 10'h007, 10'h01F, 10'h03F, 10'h07F, 10'h0FF, 10'h3FF
	};

	typedef struct packed {
		logic       forceCompare;
		logic [1:0] compareOutputMode;
		logic [1:0] waveformMode;
		logic [2:0] clockSelect;
	} tmr8_ctrl_type;

endpackage

//--- src/tmr8_output_compare.sv
// 8-bit timer/counter with one output compare channel and an AXI4-Lite register slave
// Overview of operation
// R1 - each tick clears, increments or decrements by mode
// R2 - clock select zero stops all ticks
// R3 - counter readable and writable at any time
// R4 - counter write beats any tick update
// R5 - bottom indication when counter equals zero
// R6 - overflow flag set per mode, irq capable
// R7 - comparator signals match when counter equals compare
// R8 - match sets compare flag on tick
// R9 - enabled compare flag requests irq, acknowledge clears
// R10 - writing one clears compare flag
// R11 - output formed from match, mode, max, bottom
// R12 - compare double buffered in PWM modes only
// R13 - buffered: accesses reach buffer, else active
// R14 - force compare updates output, no flag; the code does so only when the written waveform mode is not a PWM mode
// R15 - counter write blocks match next tick
// R16 - software avoids writing counter equal compare
// R17 - software sets output before enabling pin
// R18 - output level kept across mode change
// R19 - output mode bits act immediately
// R20 - max indication when counter equals 255
//
// Register access over AXI4-Lite and the address map were decided locally.
module tmr8_output_compare
	import tmr8_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output wire logic              awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output wire logic              wready,
	output wire logic [1:0]        bresp,
	output wire logic              bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output wire logic              arready,
	output wire logic [DATA_W-1:0] rdata,
	output wire logic [1:0]        rresp,
	output wire logic              rvalid,
	input  wire logic              rready,
	input  wire logic              compareIrqAck,
	input  wire logic              overflowIrqAck,
	output wire logic              compareIrq,
	output wire logic              overflowIrq,
	output wire logic              compareOutputPin,
	output wire logic              compareOutputEnable
);
	// bus slave state
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [DATA_W-1:0] rdata_q;
	logic              awHave_q;
	logic              wHave_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [7:0]        wByte_q;
	logic              wLane_q;
	// timer state
	tmr8_ctrl_type     ctrl_q;
	logic [CNT_W-1:0]  countValue_q;
	logic [CNT_W-1:0]  compareActive_q;
	logic [CNT_W-1:0]  compareBuffer_q;
	logic              countDown_q;
	logic              blockMatch_q;
	logic [PRESC_W-1:0] prescale_q;
	logic              overflowFlag_q;
	logic              compareFlag_q;
	logic [1:0]        irqEnable_q;
	logic              compareIrq_q;
	logic              overflowIrq_q;
	logic              ocLevel_q;
	logic              pinEnable_q;
	logic              awTake;
	logic              wTake;
	logic              arTake;
	logic              doWrite;
	logic              wrMapped;
	logic              wrCtrl;
	logic              wrCount;
	logic              wrCompare;
	logic              wrFlags;
	logic              wrIrqEn;
	tmr8_ctrl_type     ctrlWr;
	logic              timerTick;
	logic              isPwm;
	logic              atBottom;
	logic              atMax;
	logic              match;
	logic              matchHit;
	logic              wrapTop;
	logic              forceHit;
	logic              overflowSet;
	logic              overflowFlag_d;
	logic              compareFlag_d;
	logic [CNT_W-1:0]  countValue_d;
	logic [DATA_W-1:0] readData;
	logic              readMapped;
	assign awready             = awready_q;
	assign wready              = wready_q;
	assign bvalid              = bvalid_q;
	assign bresp               = bresp_q;
	assign arready             = arready_q;
	assign rvalid              = rvalid_q;
	assign rresp               = rresp_q;
	assign rdata               = rdata_q;
	assign compareIrq          = compareIrq_q;
	assign overflowIrq         = overflowIrq_q;
	assign compareOutputPin    = ocLevel_q;
	assign compareOutputEnable = pinEnable_q;
	// write address and data taken in either order, then one response
	assign awTake  = awvalid & awready_q;
	assign wTake   = wvalid & wready_q;
	assign arTake  = arvalid & arready_q;
	assign doWrite = awHave_q & wHave_q & ~bvalid_q;
	assign wrMapped  = (awAddr_q == CTRL_OFS) | (awAddr_q == COUNT_OFS) | (awAddr_q == COMPARE_OFS)
		| (awAddr_q == FLAGS_OFS) | (awAddr_q == IRQEN_OFS);
	assign wrCtrl    = doWrite & wLane_q & (awAddr_q == CTRL_OFS);
	assign wrCount   = doWrite & wLane_q & (awAddr_q == COUNT_OFS);
	assign wrCompare = doWrite & wLane_q & (awAddr_q == COMPARE_OFS);
	assign wrFlags   = doWrite & wLane_q & (awAddr_q == FLAGS_OFS);
	assign wrIrqEn   = doWrite & wLane_q & (awAddr_q == IRQEN_OFS);
	assign ctrlWr    = tmr8_ctrl_type'(wByte_q);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awHave_q  <= 1'b0;
			wHave_q   <= 1'b0;
			awAddr_q  <= '0;
			wByte_q   <= 8'h00;
			wLane_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (doWrite) begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (awTake) begin
					awHave_q <= 1'b1;
					awAddr_q <= awaddr;
				end
				if (wTake) begin
					wHave_q <= 1'b1;
					wByte_q <= wdata[7:0];
					wLane_q <= wstrb[0];
				end
				if (bvalid_q & bready) begin
					bvalid_q <= 1'b0;
				end
			end
			awready_q <= ~doWrite & ~(awHave_q | awTake) & ~(bvalid_q & ~bready);
			wready_q  <= ~doWrite & ~(wHave_q | wTake) & ~(bvalid_q & ~bready);
		end
	end
	// read path, one outstanding read
	always_comb begin
		readData   = '0;
		readMapped = 1'b1;
		case (araddr)
			CTRL_OFS: begin
				readData[6:0] = {ctrl_q.compareOutputMode, ctrl_q.waveformMode, ctrl_q.clockSelect};
			end
			COUNT_OFS: begin
				readData[CNT_W-1:0] = countValue_q; // R3
			end
			COMPARE_OFS: begin
				readData[CNT_W-1:0] = isPwm ? compareBuffer_q : compareActive_q; // R13
			end
			FLAGS_OFS: begin
				readData[FLAG_OVF_BIT] = overflowFlag_q;
				readData[FLAG_CMP_BIT] = compareFlag_q;
			end
			IRQEN_OFS: begin
				readData[1:0] = irqEnable_q;
			end
			default: begin
				readMapped = 1'b0;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
		end else begin
			if (arTake) begin
				rvalid_q <= 1'b1;
				rdata_q  <= readData;
				rresp_q  <= readMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q & rready) begin
				rvalid_q <= 1'b0;
			end
			arready_q <= ~arTake & ~(rvalid_q & ~rready);
		end
	end
	// control register; force bit is a strobe, never stored
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_q      <= tmr8_ctrl_type'(CTRL_RESET);
			irqEnable_q <= IRQEN_RESET;
			pinEnable_q <= 1'b0;
		end else begin
			if (wrCtrl) begin
				ctrl_q              <= ctrlWr;
				ctrl_q.forceCompare <= 1'b0;
			end
			if (wrIrqEn) begin
				irqEnable_q <= wByte_q[1:0];
			end
			pinEnable_q <= wrCtrl ? (ctrlWr.compareOutputMode != COM_OFF)
				: (ctrl_q.compareOutputMode != COM_OFF); // R19
		end
	end
	// timer tick from free running prescaler
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + 1'b1;
		end
	end
	assign timerTick = (ctrl_q.clockSelect != 3'h0)
		& ((prescale_q & PRESCALE_MASK[ctrl_q.clockSelect]) == PRESCALE_MASK[ctrl_q.clockSelect]); // R2
	assign isPwm    = (ctrl_q.waveformMode == WAVE_PHASE_PWM) | (ctrl_q.waveformMode == WAVE_FAST_PWM);
	assign atBottom = (countValue_q == COUNT_BOTTOM); // R5
	assign atMax    = (countValue_q == COUNT_MAX); // R20
	assign match    = (countValue_q == compareActive_q); // R7
	assign matchHit = timerTick & match & ~blockMatch_q & ~wrCount; // R15
	assign wrapTop  = timerTick & atMax & ~countDown_q & ~wrCount;
	assign forceHit = wrCtrl & ctrlWr.forceCompare
		& (ctrlWr.waveformMode != WAVE_PHASE_PWM) & (ctrlWr.waveformMode != WAVE_FAST_PWM); // R14
	// counter next value
	always_comb begin
		countValue_d = countValue_q;
		if (wrCount) begin
			countValue_d = wByte_q; // R4
		end else if (timerTick) begin
			case (ctrl_q.waveformMode) // R1
				WAVE_CLEAR_ON_MATCH: begin
					countValue_d = matchHit ? COUNT_BOTTOM : countValue_q + 1'b1;
				end
				WAVE_PHASE_PWM: begin
					if (countDown_q) begin
						countValue_d = atBottom ? countValue_q + 1'b1 : countValue_q - 1'b1;
					end else begin
						countValue_d = atMax ? countValue_q - 1'b1 : countValue_q + 1'b1;
					end
				end
				default: begin
					countValue_d = countValue_q + 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			countValue_q <= COUNT_BOTTOM;
			countDown_q  <= 1'b0;
			blockMatch_q <= 1'b0;
		end else begin
			countValue_q <= countValue_d;
			if (ctrl_q.waveformMode != WAVE_PHASE_PWM) begin
				countDown_q <= 1'b0;
			end else if (timerTick & ~wrCount) begin
				if (~countDown_q & atMax) begin
					countDown_q <= 1'b1;
				end else if (countDown_q & atBottom) begin
					countDown_q <= 1'b0;
				end
			end
			if (wrCount) begin
				blockMatch_q <= 1'b1; // R15
			end else if (timerTick) begin
				blockMatch_q <= 1'b0;
			end
		end
	end
	// compare register, buffered while a PWM mode is selected
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			compareActive_q <= COMPARE_RESET;
			compareBuffer_q <= COMPARE_RESET;
		end else begin
			if (wrCompare) begin
				compareBuffer_q <= wByte_q; // R13
			end
			if (wrCompare & ~isPwm) begin
				compareActive_q <= wByte_q; // R12
			end else if (isPwm & wrapTop) begin
				compareActive_q <= compareBuffer_q; // R12
			end
		end
	end
	// flags: hardware set wins over software or acknowledge clear
	assign overflowSet = timerTick & ~wrCount & (ctrl_q.waveformMode == WAVE_PHASE_PWM
		? (countDown_q & atBottom) : atMax); // R6
	assign overflowFlag_d = overflowSet
		| (overflowFlag_q & ~(wrFlags & wByte_q[FLAG_OVF_BIT]) & ~overflowIrqAck);
	assign compareFlag_d = matchHit // R8
		| (compareFlag_q & ~(wrFlags & wByte_q[FLAG_CMP_BIT]) & ~compareIrqAck); // R10

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			overflowFlag_q <= 1'b0;
			compareFlag_q  <= 1'b0;
			compareIrq_q   <= 1'b0;
			overflowIrq_q  <= 1'b0;
		end else begin
			overflowFlag_q <= overflowFlag_d;
			compareFlag_q  <= compareFlag_d;
			compareIrq_q   <= compareFlag_d & irqEnable_q[FLAG_CMP_BIT]; // R9
			overflowIrq_q  <= overflowFlag_d & irqEnable_q[FLAG_OVF_BIT]; // R6
		end
	end
	// waveform generator; level held across mode changes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ocLevel_q <= 1'b0;
		end else if (forceHit) begin
			case (ctrlWr.compareOutputMode) // R14
				COM_TOGGLE: ocLevel_q <= ~ocLevel_q;
				COM_CLEAR:  ocLevel_q <= 1'b0;
				COM_SET:    ocLevel_q <= 1'b1;
				default:    ocLevel_q <= ocLevel_q;
			endcase
		end else begin
			case (ctrl_q.waveformMode) // R11
				WAVE_FAST_PWM: begin
					if (ctrl_q.compareOutputMode[1] & wrapTop) begin
						ocLevel_q <= ~ctrl_q.compareOutputMode[0];
					end else if (ctrl_q.compareOutputMode[1] & matchHit) begin
						ocLevel_q <= ctrl_q.compareOutputMode[0];
					end
				end
				WAVE_PHASE_PWM: begin
					if (ctrl_q.compareOutputMode[1] & matchHit) begin
						ocLevel_q <= countDown_q ? ~ctrl_q.compareOutputMode[0] : ctrl_q.compareOutputMode[0];
					end
				end
				default: begin
					if (matchHit) begin
						case (ctrl_q.compareOutputMode) // R19
							COM_TOGGLE: ocLevel_q <= ~ocLevel_q;
							COM_CLEAR:  ocLevel_q <= 1'b0;
							COM_SET:    ocLevel_q <= 1'b1;
							default:    ocLevel_q <= ocLevel_q; // R18
						endcase
					end
				end
			endcase
		end
	end
endmodule // tmr8_output_compare

//--- testbench/tmr8_output_compare_props.sv
// concurrent checks on the bus ports, compare irq and output pin of the 8-bit timer
module tmr8_output_compare_props
	import tmr8_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              srst,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic              compareIrq,
	input wire logic              compareOutputPin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_wtake;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_wans;
		!awready && !wready ##1 bvalid;
	endsequence
	a_write_answer: assert property (s_wtake |=> s_wans) else $error("write answer late");
	a_ready_back: assert property (bvalid && bready |=> !bvalid && awready && wready) else $error("no ready");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp lost");
	a_aw_refuse: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("read late");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata lost");
	a_ar_refuse: assert property (rvalid |-> !arready) else $error("read taken early");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !bvalid && !rvalid && !compareIrq
		&& !compareOutputPin) else $error("outputs active after reset");
endmodule // tmr8_output_compare_props

bind tmr8_output_compare tmr8_output_compare_props i_tmr8_output_compare_props(.sys_clk(sys_clk), .srst(srst),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.compareIrq(compareIrq), .compareOutputPin(compareOutputPin));

//--- testbench/test_tmr8_output_compare.sv
// self-checking bench for the 8-bit timer with output compare
module test_tmr8_output_compare
	import tmr8_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] OFS [5] = '{CTRL_OFS, COUNT_OFS, COMPARE_OFS, FLAGS_OFS, IRQEN_OFS};
	localparam logic [1:0] FCOM [3] = '{COM_CLEAR, COM_TOGGLE, COM_SET};
	localparam logic       FPIN [3] = '{1'b0, 1'b1, 1'b1};
	logic              sys_clk = 1'b0;
	logic              srst = 1'b1;
	logic [7:0]        awaddr = 8'h00;
	logic [7:0]        araddr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	logic [3:0]        wstrb = 4'h0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic              compareIrqAck = 1'b0, overflowIrqAck = 1'b0;
	wire logic         awready, wready, bvalid, arready, rvalid, compareIrq, overflowIrq, pin, pinEn;
	wire logic [1:0]   bresp, rresp;
	wire logic [31:0]  rdata;
	logic [31:0]       v;
	int                fails = 0;
	int                cmpCount = 0;

	always #50 sys_clk = ~sys_clk;

	tmr8_output_compare i_tmr8_output_compare(.sys_clk(sys_clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .compareIrqAck(compareIrqAck),
		.overflowIrqAck(overflowIrqAck), .compareIrq(compareIrq), .overflowIrq(overflowIrq),
		.compareOutputPin(pin), .compareOutputEnable(pinEn));

	task automatic give_verdict();
		if (fails == 0 && cmpCount > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// response ready raised only after the answer shows, so holding is exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge sys_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready) break;
			if (bvalid === 1'b1) bready <= 1'b1;
		end
		if (n == 99) begin
			fails++;
			give_verdict();
		end
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge sys_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready) break;
			if (rvalid === 1'b1) rready <= 1'b1;
		end
		if (n == 99) begin
			fails++;
			give_verdict();
		end
		rready <= 1'b0;
		d = rdata;
		check(32'(rresp), 32'(er));
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		rd(a, got);
		check(got, exp);
	endtask

	function automatic logic [31:0] ctl(input logic f, input logic [1:0] m, input logic [1:0] w, input logic [2:0] c);
		tmr8_ctrl_type t;
		t = '{f, m, w, c};
		return 32'(t);
	endfunction

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		foreach (OFS[i]) rdchk(OFS[i], 32'h0);
		wr(8'h14, 32'h1, RESP_SLVERR);
		rd(8'h14, v, RESP_SLVERR);
		wr(COUNT_OFS, 32'h05);
		repeat (20) @(posedge sys_clk);
		rdchk(COUNT_OFS, 32'h05);
		wr(COMPARE_OFS, 32'h10);
		wr(COUNT_OFS, 32'h10);
		wr(CTRL_OFS, ctl(1'b0, COM_TOGGLE, WAVE_NORMAL, 3'h1));
		rdchk(FLAGS_OFS, 32'h0);
		repeat (300) @(posedge sys_clk);
		wr(CTRL_OFS, ctl(1'b0, COM_TOGGLE, WAVE_NORMAL, 3'h0));
		rdchk(FLAGS_OFS, 32'h3);
		check(32'({pin, pinEn}), 32'h3);
		wr(IRQEN_OFS, 32'h3);
		repeat (2) @(posedge sys_clk);
		check(32'({compareIrq, overflowIrq}), 32'h3);
		compareIrqAck <= 1'b1;
		@(posedge sys_clk);
		compareIrqAck <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(32'({compareIrq, overflowIrq}), 32'h1);
		wr(FLAGS_OFS, 32'h0);
		rdchk(FLAGS_OFS, 32'h1);
		wr(FLAGS_OFS, 32'h1);
		rdchk(FLAGS_OFS, 32'h0);
		foreach (FCOM[i]) begin
			wr(CTRL_OFS, ctl(1'b1, FCOM[i], WAVE_NORMAL, 3'h0));
			check(32'(pin), 32'(FPIN[i]));
		end
		rdchk(FLAGS_OFS, 32'h0);
		wr(CTRL_OFS, ctl(1'b0, COM_CLEAR, WAVE_FAST_PWM, 3'h0));
		check(32'(pin), 32'h1);
		wr(COMPARE_OFS, 32'h40);
		rdchk(COMPARE_OFS, 32'h40);
		wr(COUNT_OFS, 32'h38);
		wr(CTRL_OFS, ctl(1'b0, COM_CLEAR, WAVE_FAST_PWM, 3'h1));
		repeat (20) @(posedge sys_clk);
		wr(CTRL_OFS, ctl(1'b0, COM_CLEAR, WAVE_FAST_PWM, 3'h0));
		check(32'(pin), 32'h1);
		rdchk(FLAGS_OFS, 32'h0);
		wr(CTRL_OFS, 32'h0);
		wr(COMPARE_OFS, 32'h09);
		wr(COUNT_OFS, 32'h00);
		wr(CTRL_OFS, ctl(1'b0, COM_OFF, WAVE_CLEAR_ON_MATCH, 3'h1));
		repeat (3) begin
			rd(COUNT_OFS, v);
			check(32'(v <= 32'h9), 32'h1);
		end
		rdchk(FLAGS_OFS, 32'h2);
		check(32'({pin, pinEn, compareIrq}), 32'h5);
		wr(COUNT_OFS, 32'h80);
		rd(COUNT_OFS, v);
		check(32'(v >= 32'h80 && v < 32'h90), 32'h1);
		wr(CTRL_OFS, 32'h0);
		wr(FLAGS_OFS, 32'h2);
		rdchk(FLAGS_OFS, 32'h0);
		wr(COUNT_OFS, 32'h05);
		wr(CTRL_OFS, ctl(1'b0, COM_CLEAR, WAVE_PHASE_PWM, 3'h1));
		repeat (20) @(posedge sys_clk);
		check(32'(pin), 32'h0);
		rdchk(FLAGS_OFS, 32'h2);
		repeat (480) @(posedge sys_clk);
		wr(CTRL_OFS, ctl(1'b0, COM_CLEAR, WAVE_PHASE_PWM, 3'h0));
		check(32'(pin), 32'h1);
		rdchk(FLAGS_OFS, 32'h3);
		rdchk(COUNT_OFS, 32'h04);
		give_verdict();
	end
endmodule // test_tmr8_output_compare
